/* design/tsc_regs.sv */
// Tile status and configuration register bank with an Avalon-MM slave port.
`timescale 1ns/1ns

module tsc_regs #(
  parameter logic [31:0] RAM_BYTES = tsc_pkg::MEM_SIZE_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic [tsc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tsc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [tsc_pkg::DATA_W-1:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic pll_lock,
  input wire tsc_pkg::tsc_straps_s straps,
  input wire logic [31:0] otp_security_word,
  input wire logic [1:0] osc_tick,
  input wire logic dbg_enter,
  input wire logic [tsc_pkg::SSR_W-1:0] saved_status_word,
  input wire logic jtag_cfg_req,
  output logic jtag_cfg_grant,
  output tsc_pkg::tsc_sec_ctrl_s sec_ctrl,
  output logic boot_go,
  output logic boot_from_otp,
  output logic booted
);

  tsc_pkg::tsc_boot_e state;
  tsc_pkg::tsc_boot_e next_state;
  logic lock_meta;
  logic lock_sync;
  tsc_pkg::tsc_straps_s straps_meta;
  tsc_pkg::tsc_straps_s straps_sync;
  tsc_pkg::tsc_straps_s straps_held;
  logic [1:0] tick_meta;
  logic [1:0] tick_sync;
  logic [1:0] tick_prev;
  logic [tsc_pkg::OSC_W-1:0] osc_a;
  logic [tsc_pkg::OSC_W-1:0] osc_b;
  logic [31:0] security;
  logic [31:0] dbg_ssr;
  logic ack;
  logic [31:0] next_readdata;
  logic next_hit;
  logic wr_take;

  // Applies the byte enables to the write data and keeps old bytes elsewhere.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Replaces only the bits under a mask, so reserved bits keep their zero.
  function automatic logic [31:0] masked_update(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Pins and the lock indicator arrive from outside the clock domain.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= pll_lock;
      lock_sync <= lock_meta;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      straps_meta <= '0;
      straps_sync <= '0;
    end else begin
      straps_meta <= straps;
      straps_sync <= straps_meta;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      tsc_pkg::TSC_WAIT_LOCK: begin
        if (lock_sync) begin
          next_state = tsc_pkg::TSC_LOAD;
        end
      end
      tsc_pkg::TSC_LOAD: begin
        next_state = tsc_pkg::TSC_RUN;
      end
      tsc_pkg::TSC_RUN: begin
        next_state = tsc_pkg::TSC_RUN;
      end
      default: begin
        next_state = tsc_pkg::TSC_WAIT_LOCK;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= tsc_pkg::TSC_WAIT_LOCK;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_go <= 1'b0;
      booted <= 1'b0;
    end else begin
      boot_go <= (state == tsc_pkg::TSC_LOAD);
      booted <= (state == tsc_pkg::TSC_LOAD) || booted;
    end
  end

  // Straps are caught after release, once the clock is known good.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      straps_held <= '0;
    end else if (state == tsc_pkg::TSC_LOAD) begin
      straps_held <= straps_sync;
    end
  end

  // Bus handshake: one wait cycle, so read data are registered and stand when taken.
  assign wr_take = ack && avs_write;
  assign avs_waitrequest = !ack;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // Load from OTP, then software writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      security <= '0;
    end else if (state == tsc_pkg::TSC_LOAD) begin
      security <= otp_security_word & tsc_pkg::SEC_WR_MASK;
    end else if (wr_take && avs_address == tsc_pkg::ADDR_SECURITY &&
                 !security[tsc_pkg::SEC_WLOCK]) begin
      security <= masked_update(security, merge_bytes(security, avs_writedata, avs_byteenable),
                                tsc_pkg::SEC_WR_MASK);
    end
  end

  assign sec_ctrl.jtag_tap_en = !security[tsc_pkg::SEC_JTAG_OFF];
  assign sec_ctrl.jtag_cfg_en = !security[tsc_pkg::SEC_JTAG_CFG_OFF];
  assign jtag_cfg_grant = jtag_cfg_req && !security[tsc_pkg::SEC_JTAG_CFG_OFF];
  assign sec_ctrl.global_debug_en = !security[tsc_pkg::SEC_GDBG_OFF];
  assign sec_ctrl.secure_boot = security[tsc_pkg::SEC_SECURE_BOOT];
  assign boot_from_otp = security[tsc_pkg::SEC_SECURE_BOOT];
  assign sec_ctrl.otp_redundancy = security[tsc_pkg::SEC_REDUNDANT];
  assign sec_ctrl.sector_prog_en = ~(security[tsc_pkg::SEC_SECTOR_LSB +: 4] |
                                     {4{security[tsc_pkg::SEC_MASTER_LOCK]}});

  // Oscillator edges are synchronised; the edge detector compares the second stage with its delayed copy.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      tick_meta <= '0;
      tick_sync <= '0;
      tick_prev <= '0;
    end else begin
      tick_meta <= osc_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  // Counts use the power-on reset only, so a system reset leaves them.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      osc_a <= '0;
    end else if (tick_sync[0] && !tick_prev[0]) begin
      osc_a <= osc_a + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      osc_b <= '0;
    end else if (tick_sync[1] && !tick_prev[1]) begin
      osc_b <= osc_b + 1'b1;
    end
  end

  // Capture on entry; the capture wins over a write in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbg_ssr <= '0;
    end else if (dbg_enter) begin
      dbg_ssr <= {21'h00_0000, saved_status_word} & tsc_pkg::SSR_WR_MASK;
    end else if (wr_take && avs_address == tsc_pkg::ADDR_DBG_SSR) begin
      dbg_ssr <= masked_update(dbg_ssr, merge_bytes(dbg_ssr, avs_writedata, avs_byteenable),
                               tsc_pkg::SSR_WR_MASK);
    end
  end

  // Read decode; unmapped addresses read zero with a decode error.
  always_comb begin
    next_readdata = '0;
    next_hit = 1'b1;
    unique case (avs_address)
      tsc_pkg::ADDR_BOOT_STATE: begin
        next_readdata[tsc_pkg::BOOT_PROC_LSB +: 8] = straps_held.proc_num;
        next_readdata[tsc_pkg::BOOT_OVERRIDE] = security[tsc_pkg::SEC_SECURE_BOOT];
        next_readdata[tsc_pkg::BOOT_CORE1_OFF] = straps_held.core1_off;
        next_readdata[tsc_pkg::BOOT_SKIP_POLL] = straps_held.skip_otp_poll;
        next_readdata[tsc_pkg::BOOT_FROM_RAM] = straps_held.boot_ram;
        next_readdata[tsc_pkg::BOOT_FROM_JTAG] = straps_held.boot_jtag;
        next_readdata[tsc_pkg::BOOT_PLL_LSB +: 2] = straps_held.pll_mode;
      end
      tsc_pkg::ADDR_SECURITY: begin
        next_readdata = security;
      end
      tsc_pkg::ADDR_OSC_A: begin
        next_readdata[tsc_pkg::OSC_W-1:0] = osc_a;
      end
      tsc_pkg::ADDR_OSC_B: begin
        next_readdata[tsc_pkg::OSC_W-1:0] = osc_b;
      end
      tsc_pkg::ADDR_MEM_SIZE: begin
        next_readdata = RAM_BYTES & tsc_pkg::MEM_SIZE_MASK;
      end
      tsc_pkg::ADDR_DBG_SSR: begin
        next_readdata = dbg_ssr;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
      avs_response <= tsc_pkg::RESP_OKAY;
    end else if ((avs_read || avs_write) && !ack) begin
      avs_readdata <= avs_read ? next_readdata : '0;
      avs_response <= next_hit ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_DECERR;
    end
  end

endmodule

/* design/tsc_pkg.sv */
// Constants, field layouts and carrier types for the tile status and configuration bank.
package tsc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_BOOT_STATE = 8'h03;
  localparam logic [7:0] IDX_SECURITY = 8'h05;
  localparam logic [7:0] IDX_OSC_A = 8'h09;
  localparam logic [7:0] IDX_OSC_B = 8'h0A;
  localparam logic [7:0] IDX_MEM_SIZE = 8'h0C;
  localparam logic [7:0] IDX_DBG_SSR = 8'h10;
  localparam logic [7:0] ADDR_BOOT_STATE = 8'(IDX_BOOT_STATE * 4);
  localparam logic [7:0] ADDR_SECURITY = 8'(IDX_SECURITY * 4);
  localparam logic [7:0] ADDR_OSC_A = 8'(IDX_OSC_A * 4);
  localparam logic [7:0] ADDR_OSC_B = 8'(IDX_OSC_B * 4);
  localparam logic [7:0] ADDR_MEM_SIZE = 8'(IDX_MEM_SIZE * 4);
  localparam logic [7:0] ADDR_DBG_SSR = 8'(IDX_DBG_SSR * 4);

  // Boot status field positions.
  localparam int unsigned BOOT_PROC_LSB = 16;
  localparam int unsigned BOOT_OVERRIDE = 8;
  localparam int unsigned BOOT_CORE1_OFF = 5;
  localparam int unsigned BOOT_SKIP_POLL = 4;
  localparam int unsigned BOOT_FROM_RAM = 3;
  localparam int unsigned BOOT_FROM_JTAG = 2;
  localparam int unsigned BOOT_PLL_LSB = 0;

  // Security word field positions and the mask of its writable bits.
  localparam int unsigned SEC_WLOCK = 31;
  localparam int unsigned SEC_GDBG_OFF = 14;
  localparam int unsigned SEC_MASTER_LOCK = 12;
  localparam int unsigned SEC_SECTOR_LSB = 8;
  localparam int unsigned SEC_REDUNDANT = 7;
  localparam int unsigned SEC_SECURE_BOOT = 5;
  localparam int unsigned SEC_JTAG_CFG_OFF = 4;
  localparam int unsigned SEC_JTAG_OFF = 0;
  localparam logic [31:0] SEC_WR_MASK = 32'h8000_5FB1;

  // Oscillator count, memory size and saved status layouts.
  localparam int unsigned OSC_W = 16;
  localparam logic [31:0] MEM_SIZE_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] MEM_SIZE_DEFAULT = 32'h0004_0000;
  localparam int unsigned SSR_W = 11;
  localparam logic [31:0] SSR_WR_MASK = 32'h0000_07DF;

  // Avalon response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Least reset pulse that the system must give.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RST_MIN_NS = 100;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    TSC_WAIT_LOCK = 2'b00,
    TSC_LOAD = 2'b01,
    TSC_RUN = 2'b10
  } tsc_boot_e;

  typedef struct packed {
    logic [7:0] proc_num;
    logic core1_off;
    logic skip_otp_poll;
    logic boot_ram;
    logic boot_jtag;
    logic [1:0] pll_mode;
  } tsc_straps_s;

  typedef struct packed {
    logic jtag_tap_en;
    logic jtag_cfg_en;
    logic global_debug_en;
    logic secure_boot;
    logic otp_redundancy;
    logic [3:0] sector_prog_en;
  } tsc_sec_ctrl_s;

endpackage

/* verif/tsc_regs_asserts.sv */
// Concurrent checks on the ports of the tile status and configuration bank.
`timescale 1ns/1ns
module tsc_regs_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pll_lock,
  input wire logic jtag_cfg_req,
  input wire logic jtag_cfg_grant,
  input wire tsc_pkg::tsc_sec_ctrl_s sec_ctrl,
  input wire logic boot_go,
  input wire logic boot_from_otp,
  input wire logic booted
);
  logic req;
  assign req = avs_read || avs_write;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_taken;
    req && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_taken |=> s_answer)
    else $error("answer not one cycle after request");
  AST_IDLE_WAIT: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  AST_RD_HOLD: assert property (!req |=> $stable(avs_readdata))
    else $error("read data moved while idle");
  AST_GRANT: assert property (jtag_cfg_grant == (jtag_cfg_req && sec_ctrl.jtag_cfg_en))
    else $error("config grant wrong");
  AST_OTP_BOOT: assert property (boot_from_otp == sec_ctrl.secure_boot)
    else $error("boot source wrong");
  AST_GO_PULSE: assert property (boot_go |=> !boot_go && booted)
    else $error("boot start not a single pulse");
  AST_BOOTED_HOLD: assert property (booted |=> booted)
    else $error("booted dropped");
  AST_BOOTED_CAUSE: assert property ($rose(booted) |-> boot_go)
    else $error("booted set without boot start");
  AST_GO_LOCK: assert property (boot_go |-> $past(pll_lock, 2))
    else $error("boot started without lock");
endmodule
bind tsc_regs tsc_regs_asserts u_chk (.clk, .rstn, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .pll_lock, .jtag_cfg_req, .jtag_cfg_grant, .sec_ctrl, .boot_go,
  .boot_from_otp, .booted);

/* verif/tb.sv */
// Self-checking bench for the tile status and configuration bank.
`timescale 1ns/1ns
module tb;
  logic clk, rstn, por_n, avs_read, avs_write, pll_lock, dbg_enter, jtag_cfg_req;
  logic jtag_cfg_grant, avs_waitrequest, boot_go, boot_from_otp, booted;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, otp_word, rd;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, osc_tick, resp;
  logic [10:0] ssw;
  tsc_pkg::tsc_straps_s straps;
  tsc_pkg::tsc_sec_ctrl_s sec_ctrl;
  int failures, check_count;
  `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end

  // Odd size bits show that the two low bits are masked.
  tsc_regs #(.RAM_BYTES(32'h0004_0003)) uut (.clk, .rstn, .por_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
    .avs_waitrequest, .pll_lock, .straps, .otp_security_word(otp_word), .osc_tick,
    .dbg_enter, .saved_status_word(ssw), .jtag_cfg_req, .jtag_cfg_grant, .sec_ctrl,
    .boot_go, .boot_from_otp, .booted);

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end

  task wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Request is held until waitrequest is seen low at a rising edge.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    // Only the bench timeout ends a wait whose answer never comes.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(s, e, rd)
  endtask

  task tick(input int b, input int n);
    repeat (n) begin
      osc_tick[b] <= 1'b1;
      repeat (4) @(posedge clk);
      osc_tick[b] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // Reset is held five cycles, longer than the least pulse the system must give.
  task boot;
    rstn <= 1'b0;
    pll_lock <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("waitreq_rst", 1'b1, avs_waitrequest)
    `CHK("booted_rst", 1'b0, booted)
    rstn <= 1'b1;
    por_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("booted_nolock", 1'b0, booted)
    pll_lock <= 1'b1;
    repeat (40) if (booted !== 1'b1) @(posedge clk);
    `CHK("booted", 1'b1, booted)
  endtask

  initial begin
    rstn = 0;
    por_n = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pll_lock = 0;
    straps = 14'h296A;
    otp_word = 32'h7FFF_FFFF;
    osc_tick = 2'h0;
    dbg_enter = 0;
    // Reserved bit 5 is set here so that its removal on capture is seen.
    ssw = 11'h4E3;
    jtag_cfg_req = 1;
    failures = 0;
    check_count = 0;
    boot();
    rchk("security", tsc_pkg::ADDR_SECURITY, 32'h0000_5FB1);
    `CHK("sec_ctrl", 9'h030, sec_ctrl)
    `CHK("grant", 1'b0, jtag_cfg_grant)
    `CHK("otp_boot", 1'b1, boot_from_otp)
    rchk("boot_state", tsc_pkg::ADDR_BOOT_STATE, 32'h00A5_012A);
    xfer(1'b1, tsc_pkg::ADDR_BOOT_STATE, 32'hFFFF_FFFF);
    rchk("boot_state_ro", tsc_pkg::ADDR_BOOT_STATE, 32'h00A5_012A);
    xfer(1'b1, tsc_pkg::ADDR_SECURITY, 32'h7FFE_A32E);
    rchk("security_wr", tsc_pkg::ADDR_SECURITY, 32'h0000_0320);
    `CHK("sec_ctrl_wr", 9'h1EC, sec_ctrl)
    `CHK("grant_wr", 1'b1, jtag_cfg_grant)
    jtag_cfg_req <= 1'b0;
    @(negedge clk);
    `CHK("grant_noreq", 1'b0, jtag_cfg_grant)
    @(posedge clk);
    jtag_cfg_req <= 1'b1;
    xfer(1'b1, tsc_pkg::ADDR_SECURITY, 32'h0000_1000);
    // The write lands at the edge that ends the transfer, so look once it has settled.
    @(negedge clk);
    `CHK("sec_ctrl_master", 9'h1C0, sec_ctrl)
    `CHK("otp_boot_off", 1'b0, boot_from_otp)
    xfer(1'b1, tsc_pkg::ADDR_SECURITY, 32'h8000_0000);
    xfer(1'b1, tsc_pkg::ADDR_SECURITY, 32'h0000_0011);
    rchk("security_lock", tsc_pkg::ADDR_SECURITY, 32'h8000_0000);
    rchk("boot_state_pin", tsc_pkg::ADDR_BOOT_STATE, 32'h00A5_002A);
    rchk("mem_size", tsc_pkg::ADDR_MEM_SIZE, 32'h0004_0000);
    `CHK("mem_size_resp", tsc_pkg::RESP_OKAY, resp)
    xfer(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped_resp", tsc_pkg::RESP_DECERR, resp)
    `CHK("unmapped_data", 32'h0, rd)
    @(posedge clk);
    dbg_enter <= 1'b1;
    @(posedge clk);
    dbg_enter <= 1'b0;
    rchk("saved_status", tsc_pkg::ADDR_DBG_SSR, 32'h0000_04C3);
    xfer(1'b1, tsc_pkg::ADDR_DBG_SSR, 32'hFFFF_FFFF);
    rchk("saved_status_wr", tsc_pkg::ADDR_DBG_SSR, 32'h0000_07DF);
    avs_byteenable <= 4'h1;
    xfer(1'b1, tsc_pkg::ADDR_DBG_SSR, 32'h0000_0000);
    avs_byteenable <= 4'hF;
    rchk("saved_status_lane", tsc_pkg::ADDR_DBG_SSR, 32'h0000_0700);
    tick(0, 2);
    tick(1, 3);
    rchk("osc_a", tsc_pkg::ADDR_OSC_A, 32'h0000_0002);
    rchk("osc_b", tsc_pkg::ADDR_OSC_B, 32'h0000_0003);
    // A second system reset must reload the lock-protected word and keep the counts.
    boot();
    rchk("osc_b_kept", tsc_pkg::ADDR_OSC_B, 32'h0000_0003);
    rchk("osc_a_kept", tsc_pkg::ADDR_OSC_A, 32'h0000_0002);
    rchk("security_reload", tsc_pkg::ADDR_SECURITY, 32'h0000_5FB1);
    wrap_up();
  end
endmodule
